/* rtl/tefs_pkg.sv */
// constants for the timing event flag status block
// assumes one system clock; offsets are byte addresses of the serial register port
package tefs_pkg;
    localparam logic [7:0] TEFS_OFS_EVT_MID   = 8'h06;
    localparam logic [7:0] TEFS_OFS_FREQ_TOP  = 8'h07;
    localparam logic [7:0] TEFS_OFS_EVT_UPPER = 8'h08;

    localparam logic [7:0] TEFS_RST_EVT_MID   = 8'h7f;
    localparam logic [7:0] TEFS_RST_FREQ_TOP  = 8'h00;
    localparam logic [7:0] TEFS_RST_EVT_UPPER = 8'h50;

    // field positions
    localparam int TEFS_BIT_MODE_CHG  = 7;
    localparam int TEFS_BIT_REF_FAIL  = 6;
    localparam int TEFS_BIT_IN4_CHG   = 0;
    localparam int TEFS_BIT_AUX_LOCK  = 6;
    localparam int TEFS_FREQ_HI       = 18;
    localparam int TEFS_FREQ_LO       = 16;

    // operating mode codes of the main loop
    localparam logic [2:0] TEFS_MODE_FREE_RUN = 3'h1;
    localparam logic [2:0] TEFS_MODE_HOLDOVER = 3'h5;

    // reference failure: missing input cycles before the event
    localparam int TEFS_MISS_CYCLES     = 2;
    localparam int TEFS_REF_PERIOD_CLKS = 8;
endpackage

/* rtl/tefs_ref_monitor.sv */
// missing-cycle detector for the main loop's selected reference
// assumes the reference sample is synchronous to CLK and slower than CLK/2
module tefs_ref_monitor
    import tefs_pkg::*;
#(
    parameter int PERIOD_CLKS = TEFS_REF_PERIOD_CLKS,
    parameter int MISS        = TEFS_MISS_CYCLES
) (
    input  wire logic CLK,
    input  wire logic RST_B,
    input  wire logic en,
    input  wire logic ref_sample,
    output logic      fail
);
    localparam int          LIMIT = (MISS + 1) * PERIOD_CLKS;
    localparam logic [15:0] LIM16 = 16'(LIMIT);

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        ref_q;
    logic        next_fail;
    logic        edge_seen;

    always_comb begin
        edge_seen = ref_sample & ~ref_q;
        next_cnt  = cnt;
        if (!en || edge_seen) begin
            next_cnt = 16'h0000;
        end else if (cnt != LIM16) begin
            next_cnt = cnt + 16'h0001;
        end
        // one pulse only: the counter parks at the limit until an edge returns or en drops
        next_fail = en & ~edge_seen & (cnt == LIM16 - 16'h0001);
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cnt   <= 16'h0000;
            ref_q <= 1'b0;
            fail  <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            ref_q <= ref_sample;
            fail  <= next_fail;
        end
    end
endmodule

/* rtl/tefs_top.sv */
// timing event flag status: middle and upper sticky event bytes, frequency readback
// assumes register accesses are single-cycle strobes from the serial port decoder
//
// Summary of operation
// - set middle event bit 7 on each main loop mode change; sticky
// - flags clear only by writing one to their bit; zero leaves them
// - set middle event bit 6 after two missing reference input cycles, except in free-run or holdover
// - set middle event bit 0 on any valid/invalid change of input clock four
// - middle byte is event bits 15:8, bits 5:1 unused, reset 0111 1111
// - frequency readback is read-only, bits 2:0 give word bits 18:16, resets zero
module tefs_top
    import tefs_pkg::*;
#(
    parameter int REF_PERIOD_CLKS = TEFS_REF_PERIOD_CLKS
) (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    input  wire logic [2:0]  LOOP_MODE,
    input  wire logic        REF_SAMPLE,
    input  wire logic        INPUT_CLOCK_FOUR_VALID,
    input  wire logic [18:0] LOOP_FREQ,
    input  wire logic        AUX_LOOP_LOCK
);
    ////////////////////////////////////////////////////////////////////////////////
    logic       primed;
    logic [2:0] mode_q;
    logic       in4_q;
    logic       aux_q;
    logic       mode_flag;
    logic       ref_flag;
    logic       in4_flag;
    logic       aux_flag;
    logic       ref_fail;
    logic       tracking;
    logic       wr_mid;
    logic       wr_up;
    logic       mode_evt;
    logic       ref_evt;
    logic       in4_evt;
    logic       aux_evt;
    logic       next_mode_flag;
    logic       next_ref_flag;
    logic       next_in4_flag;
    logic       next_aux_flag;
    logic [7:0] mid_view;
    logic [7:0] up_view;
    logic [7:0] next_rdata;

    // no reference is tracked in free-run or holdover
    assign tracking = (LOOP_MODE != TEFS_MODE_FREE_RUN)
                    && (LOOP_MODE != TEFS_MODE_HOLDOVER);

    tefs_ref_monitor #(
        .PERIOD_CLKS (REF_PERIOD_CLKS),
        .MISS        (TEFS_MISS_CYCLES)
    ) u_ref_mon (
        .CLK        (CLK),
        .RST_B      (RST_B),
        .en         (tracking),
        .ref_sample (REF_SAMPLE),
        .fail       (ref_fail)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // event detection and sticky flags; a set in the clearing cycle wins
    always_comb begin
        wr_mid   = REG_WR && (REG_ADDR == TEFS_OFS_EVT_MID);
        wr_up    = REG_WR && (REG_ADDR == TEFS_OFS_EVT_UPPER);
        // the first cycle after reset has no valid history, so no events
        mode_evt = primed && (LOOP_MODE != mode_q);
        ref_evt  = ref_fail && tracking;
        in4_evt  = primed && (INPUT_CLOCK_FOUR_VALID != in4_q);
        aux_evt  = primed && (AUX_LOOP_LOCK != aux_q);
        next_mode_flag = mode_evt
                       | (mode_flag & ~(wr_mid & REG_WDATA[TEFS_BIT_MODE_CHG]));
        next_ref_flag  = ref_evt
                       | (ref_flag & ~(wr_mid & REG_WDATA[TEFS_BIT_REF_FAIL]));
        next_in4_flag  = in4_evt
                       | (in4_flag & ~(wr_mid & REG_WDATA[TEFS_BIT_IN4_CHG]));
        next_aux_flag  = aux_evt
                       | (aux_flag & ~(wr_up & REG_WDATA[TEFS_BIT_AUX_LOCK]));
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            primed    <= 1'b0;
            mode_q    <= 3'h0;
            in4_q     <= 1'b0;
            aux_q     <= 1'b0;
            mode_flag <= TEFS_RST_EVT_MID[TEFS_BIT_MODE_CHG];
            ref_flag  <= TEFS_RST_EVT_MID[TEFS_BIT_REF_FAIL];
            in4_flag  <= TEFS_RST_EVT_MID[TEFS_BIT_IN4_CHG];
            aux_flag  <= TEFS_RST_EVT_UPPER[TEFS_BIT_AUX_LOCK];
        end else begin
            primed    <= 1'b1;
            mode_q    <= LOOP_MODE;
            in4_q     <= INPUT_CLOCK_FOUR_VALID;
            aux_q     <= AUX_LOOP_LOCK;
            mode_flag <= next_mode_flag;
            ref_flag  <= next_ref_flag;
            in4_flag  <= next_in4_flag;
            aux_flag  <= next_aux_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path; unused bits read back their reset value, writes to 0x07 are dropped
    always_comb begin
        mid_view = TEFS_RST_EVT_MID;
        mid_view[TEFS_BIT_MODE_CHG] = mode_flag;
        mid_view[TEFS_BIT_REF_FAIL] = ref_flag;
        mid_view[TEFS_BIT_IN4_CHG]  = in4_flag;
        up_view = TEFS_RST_EVT_UPPER;
        up_view[TEFS_BIT_AUX_LOCK] = aux_flag;
        next_rdata = REG_RDATA;
        if (REG_RD) begin
            case (REG_ADDR)
                TEFS_OFS_EVT_MID:   next_rdata = mid_view;
                TEFS_OFS_FREQ_TOP:  next_rdata = {5'h00,
                                        LOOP_FREQ[TEFS_FREQ_HI:TEFS_FREQ_LO]};
                TEFS_OFS_EVT_UPPER: next_rdata = up_view;
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            REG_RDATA <= TEFS_RST_FREQ_TOP;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks are off while reset is low; mode and input clock four event checks wait for primed history
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence mode_step;
        primed && (LOOP_MODE != mode_q);
    endsequence

    sequence mid_clear(int b);
        wr_mid && REG_WDATA[b];
    endsequence

    sequence up_clear;
        wr_up && REG_WDATA[TEFS_BIT_AUX_LOCK];
    endsequence

    sequence ref_lost;
        ref_fail && tracking;
    endsequence

    mode_sets_a: assert property (mode_step |=> mode_flag)
        else $error("mode change did not set the mode flag");

    clear_one_a: assert property (
        mid_clear(TEFS_BIT_MODE_CHG) ##0 !mode_evt |=> !mode_flag)
        else $error("write of one did not clear the mode flag");

    keep_zero_a: assert property (
        mode_flag && !(wr_mid && REG_WDATA[TEFS_BIT_MODE_CHG]) |=> mode_flag)
        else $error("mode flag lost without a write of one");

    ref_fail_a: assert property (ref_lost |=> ref_flag)
        else $error("reference failure did not set its flag");

    ref_pulse_a: assert property (ref_fail |=> !ref_fail)
        else $error("reference failure is not a single pulse");

    in4_change_a: assert property (
        primed && $changed(INPUT_CLOCK_FOUR_VALID) |-> ##1 in4_flag)
        else $error("input clock four change not flagged");

    mid_unused_a: assert property (
        REG_RD && (REG_ADDR == TEFS_OFS_EVT_MID) |=> REG_RDATA[5:1] == 5'h1f)
        else $error("unused middle event bits misread");

    mid_in4_a: assert property (
        REG_RD && (REG_ADDR == TEFS_OFS_EVT_MID) |=> REG_RDATA[0] == $past(in4_flag))
        else $error("middle event bit 0 does not show its flag");

    freq_read_a: assert property (
        REG_RD && (REG_ADDR == TEFS_OFS_FREQ_TOP)
        |=> REG_RDATA == {5'h00, $past(LOOP_FREQ[18:16])})
        else $error("frequency readback wrong");

    freq_ro_a: assert property (
        REG_WR && (REG_ADDR == TEFS_OFS_FREQ_TOP) && !REG_RD |=> $stable(REG_RDATA))
        else $error("write to the frequency readback changed the read data");

    no_ref_fail_a: assert property (!tracking && !ref_flag |=> !ref_flag)
        else $error("reference failure flagged without a tracked reference");

    ref_gate_a: assert property (!tracking |=> !ref_fail)
        else $error("reference monitor failed while no reference is tracked");

    ref_clear_a: assert property (
        mid_clear(TEFS_BIT_REF_FAIL) ##0 !ref_evt |=> !ref_flag)
        else $error("write of one did not clear the reference failure flag");

    ref_keep_a: assert property (
        ref_flag && !(wr_mid && REG_WDATA[TEFS_BIT_REF_FAIL]) |=> ref_flag)
        else $error("reference failure flag lost without a write of one");

    in4_clear_a: assert property (
        mid_clear(TEFS_BIT_IN4_CHG) ##0 !in4_evt |=> !in4_flag)
        else $error("write of one did not clear the input clock four flag");

    in4_keep_a: assert property (
        in4_flag && !(wr_mid && REG_WDATA[TEFS_BIT_IN4_CHG]) |=> in4_flag)
        else $error("input clock four flag lost without a write of one");

    aux_clear_a: assert property (
        up_clear ##0 !aux_evt |=> !aux_flag)
        else $error("write of one did not clear the auxiliary lock flag");
endmodule

/* test/tb.sv */
// self-checking bench for the timing event flag status block
// assumes tefs_pkg is compiled first; the bench drives every port itself
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tefs_pkg::*;

    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic [2:0]  loop_mode = 3'h3;
    logic        ref_sample = 1'b0;
    logic        ref_run   = 1'b1;
    logic        in4_valid = 1'b1;
    logic [18:0] loop_freq = 19'h00000;
    logic        aux_lock  = 1'b0;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cycles      = 0;

    tefs_top #(.REF_PERIOD_CLKS(4)) dut_u (
        .CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .LOOP_MODE(loop_mode), .REF_SAMPLE(ref_sample),
        .INPUT_CLOCK_FOUR_VALID(in4_valid), .LOOP_FREQ(loop_freq),
        .AUX_LOOP_LOCK(aux_lock));

    always #20 clk = ~clk;

    // reference period of 4 clocks; stopping it simulates a failed reference
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (ref_run && cycles[0])
            ref_sample <= ~ref_sample;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // read data lands one edge after the strobe; compare mid-cycle, then
    // return on a rising edge so callers keep driving inputs on the edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check8(reg_rdata, exp, what);
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset_clear();
        rd(TEFS_OFS_EVT_MID, 8'h7f, "middle reset");
        rd(TEFS_OFS_FREQ_TOP, 8'h00, "freq reset");
        rd(TEFS_OFS_EVT_UPPER, 8'h50, "upper reset");
        wr(TEFS_OFS_EVT_MID, 8'h00);
        rd(TEFS_OFS_EVT_MID, 8'h7f, "zero write");
        wr(TEFS_OFS_EVT_MID, 8'hc1);
        rd(TEFS_OFS_EVT_MID, 8'h3e, "one write");
        $display("test reset_clear done");
    endtask

    task automatic test_mode_in4();
        @(posedge clk);
        loop_mode <= 3'h2;
        rd(TEFS_OFS_EVT_MID, 8'hbe, "mode change");
        repeat (6) @(posedge clk);
        rd(TEFS_OFS_EVT_MID, 8'hbe, "mode sticky");
        wr(TEFS_OFS_EVT_MID, 8'h80);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            in4_valid <= ~in4_valid;
            rd(TEFS_OFS_EVT_MID, 8'h3f, "in4 change");
            wr(TEFS_OFS_EVT_MID, 8'h01);
            rd(TEFS_OFS_EVT_MID, 8'h3e, "in4 cleared");
        end
        $display("test mode_in4 done");
    endtask

    task automatic test_ref_fail();
        @(posedge clk);
        ref_run <= 1'b0;
        rd(TEFS_OFS_EVT_MID, 8'h3e, "one period missing");
        repeat (15) @(posedge clk);
        rd(TEFS_OFS_EVT_MID, 8'h7e, "ref failed");
        ref_run <= 1'b1;
        repeat (6) @(posedge clk);
        wr(TEFS_OFS_EVT_MID, 8'h40);
        rd(TEFS_OFS_EVT_MID, 8'h3e, "ref fail cleared");
        // a mode without a tracked reference must not raise the failure
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            loop_mode <= (i == 0) ? TEFS_MODE_FREE_RUN : TEFS_MODE_HOLDOVER;
            ref_run   <= 1'b0;
            repeat (3) @(posedge clk);
            wr(TEFS_OFS_EVT_MID, 8'h80);
            repeat (20) @(posedge clk);
            rd(TEFS_OFS_EVT_MID, 8'h3e, "no fail in mode");
            ref_run <= 1'b1;
        end
        $display("test ref_fail done");
    endtask

    task automatic test_freq_aux();
        @(posedge clk);
        loop_freq <= 19'h51234;
        rd(TEFS_OFS_FREQ_TOP, 8'h05, "freq top");
        wr(TEFS_OFS_FREQ_TOP, 8'hff);
        loop_freq <= 19'h2ffff;
        rd(TEFS_OFS_FREQ_TOP, 8'h02, "freq read-only");
        rd(8'h3c, 8'h00, "unmapped read");
        wr(TEFS_OFS_EVT_UPPER, 8'h40);
        rd(TEFS_OFS_EVT_UPPER, 8'h10, "aux cleared");
        aux_lock <= 1'b1;
        rd(TEFS_OFS_EVT_UPPER, 8'h50, "aux change");
        $display("test freq_aux done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        test_reset_clear();
        test_mode_in4();
        test_ref_fail();
        test_freq_aux();
        finish_test();
    end
endmodule
